// File: rtl/rsl_top.sv
// Reset sequencing, reset-cause flags and their Wishbone registers
// How it works
// RULE1: pin pulses under three clocks ignored
// RULE2: watchdog timeout resets when reset-enabled
// RULE3: debug control bit 0 resets; debugger survives
// RULE4: stop mode: filtered pin, debug pin reset
// RULE5: core held until power-on counter expires
// RULE6: crystal enable selects longer power-on delay
// RULE7: after release, processor fetches reset vector
// RULE8: reset vector 0002H, highest vector priority
// RULE9: power-on flag set after every power-on
// RULE10: stop recovery sets stop flag
// RULE11: stop flag cleared by power-on, running timeout
// RULE12: cause register read clears three flags
// RULE13: timeout sets watchdog flag; power-on, pin recovery clear
// RULE14: software reads causes before clearing watchdog
// RULE15: pin reset sets pin flag; cleared likewise
// RULE16: reset pin synchronised before width counting
// RULE17: reserved bits read zero, clear only flags
`timescale 1ns/1ps
module rsl_top
    import rsl_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC,
    parameter int POR_XTAL_CYCLES = POR_XTAL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic por_i,
    input wire logic xtal_en_i,
    input wire logic stop_mode_i,
    input wire logic pin_reset_n_i,
    input wire logic stop_pin_reset_n_i,
    input wire logic debug_pin_i,
    input wire logic wdt_timeout_i,
    input wire logic stop_rec_i,
    input wire logic stop_rec_pin_i,
    input wire logic trap_req_i,
    input wire logic [15:0] trap_vec_i,
    output logic sys_rst_o,
    output logic vec_req_o,
    output logic [15:0] vec_addr_o,
    output logic irq_o
);
    // ************************************************************
    // State
    // ************************************************************
    rsl_state_t state, next_state;
    logic [15:0] cnt, next_cnt;
    logic pin_meta, pin_sync, next_pin_meta, next_pin_sync;
    logic [1:0] pin_cnt, next_pin_cnt;
    rsl_cause_t cause, next_cause;
    logic por_flag, next_por_flag;
    logic wd_rst_en, next_wd_rst_en;
    logic dbg_rst, next_dbg_rst;
    logic [EV_N-1:0] irq_stat, next_irq_stat;
    logic [EV_N-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_dat;
    logic next_ack, next_sys_rst, next_vec_req, next_irq;
    logic [15:0] next_vec_addr;

    logic acc, wr, rd, pin_hit, pin_hold, stop_hit, wdt_hit, src;
    logic [15:0] limit;
    logic [EV_N-1:0] ev, w1c;

    // ************************************************************
    // Reset sources
    // ************************************************************
    always_comb begin
        // Pin is asynchronous to the clock, so it is synchronised first
        next_pin_meta = pin_reset_n_i; // [RULE16]
        next_pin_sync = pin_meta; // [RULE16]
        if (pin_sync || stop_mode_i) begin
            next_pin_cnt = 2'h0;
        end else if (pin_cnt != PIN_MIN_CYC) begin
            next_pin_cnt = pin_cnt + 2'h1; // [RULE1]
        end else begin
            next_pin_cnt = pin_cnt;
        end
    end

    // Fires on the third consecutive low sample, never on shorter ones
    assign pin_hit = !pin_sync && !stop_mode_i
        && (pin_cnt == PIN_MIN_CYC - 2'h1); // [RULE1]

    // A pin still held low keeps the delay counter from running out
    assign pin_hold = !pin_sync && !stop_mode_i
        && (pin_cnt == PIN_MIN_CYC); // [RULE1]
    // The analog filter ahead of this input already dropped short pulses
    assign stop_hit = stop_mode_i
        && (!stop_pin_reset_n_i || !debug_pin_i); // [RULE4]
    assign wdt_hit = wdt_timeout_i && wd_rst_en && !stop_mode_i; // [RULE2]
    assign src = pin_hit || stop_hit || wdt_hit || dbg_rst; // [RULE3]
    // Crystal start-up needs the longer wait
    assign limit = xtal_en_i ? 16'(POR_XTAL_CYCLES - 1)
                             : 16'(POR_CYCLES - 1); // [RULE6]

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            S_HOLD: begin
                // Power-on or brownout holds everything until supply is good
                next_cnt = 16'h0000;
                if (!por_i) begin
                    next_state = S_DELAY;
                end
            end
            S_DELAY: begin
                if (src || pin_hold) begin
                    next_cnt = 16'h0000;
                end else if (cnt >= limit) begin
                    next_state = S_FETCH; // [RULE5]
                end else begin
                    next_cnt = cnt + 16'h0001; // [RULE5]
                end
            end
            S_FETCH: begin
                // A one-cycle source landing in the fetch cycle is not lost
                if (src) begin
                    next_state = S_DELAY;
                    next_cnt = 16'h0000;
                end else begin
                    next_state = S_RUN; // [RULE7]
                end
            end
            S_RUN: begin
                if (src) begin
                    next_state = S_DELAY;
                    next_cnt = 16'h0000;
                end
            end
        endcase
        if (por_i) begin
            next_state = S_HOLD; // [RULE5]
        end
        next_sys_rst = (next_state == S_HOLD)
            || (next_state == S_DELAY); // [RULE5]
        // Traps are honoured only while running, never in the fetch cycle
        // Reset vector wins over any trap request in the same cycle
        next_vec_req = (next_state == S_FETCH)
            || (trap_req_i && state == S_RUN
                && next_state == S_RUN); // [RULE8]
        next_vec_addr = (next_state == S_FETCH) ? RESET_VEC
                                                : trap_vec_i; // [RULE8]
    end

    // ************************************************************
    // Registers and Wishbone slave
    // ************************************************************
    // Ack is registered, so each access sees one wait state
    // Register bits sit in the low byte lane, so sel[0] gates writes
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;

    // Interrupt events mirror the reset causes
    always_comb begin
        ev = '0;
        ev[EV_POR] = por_i;
        ev[EV_WDT] = wdt_timeout_i;
        ev[EV_PIN] = pin_hit || (stop_mode_i && !stop_pin_reset_n_i);
        ev[EV_STOP] = stop_rec_i;
        ev[EV_DBG] = dbg_rst;
        w1c = '0;
        if (wr && wb_adr_i == ADR_IRQ_STAT) begin
            w1c = wb_dat_i[EV_N-1:0];
        end
    end

    always_comb begin
        next_cause = cause;
        next_por_flag = por_flag;
        next_wd_rst_en = wd_rst_en;
        next_dbg_rst = dbg_rst;
        next_irq_mask = irq_mask;
        next_ack = acc;
        next_dat = 32'h0000_0000; // [RULE17]
        // Clears first, so that a same-cycle event below wins
        if (rd && wb_adr_i == ADR_CAUSE) begin
            next_cause = '0; // [RULE12]
        end
        if (stop_rec_i && stop_rec_pin_i) begin
            next_cause.wdt = 1'b0; // [RULE13]
            next_cause.pin_reset_flag = 1'b0; // [RULE15]
        end
        if (wdt_timeout_i && !stop_mode_i) begin
            next_cause.stop_rec = 1'b0; // [RULE11]
        end
        if (wdt_timeout_i) begin
            next_cause.wdt = 1'b1; // [RULE13]
        end
        if (stop_rec_i) begin
            next_cause.stop_rec = 1'b1; // [RULE10]
        end
        if (ev[EV_PIN]) begin
            next_cause.pin_reset_flag = 1'b1; // [RULE15]
        end
        // Self-clears once the system reset it asked for is under way
        if (dbg_rst && state != S_RUN) begin
            next_dbg_rst = 1'b0;
        end
        if (wr) begin
            unique case (wb_adr_i)
                ADR_DBGCTL: begin
                    if (wb_dat_i[DBG_RST_BIT]) begin
                        next_dbg_rst = 1'b1; // [RULE3]
                    end
                end
                ADR_WDCTL: begin
                    // Bit 7 is write-one-to-clear, bit 0 plain read-write
                    next_wd_rst_en = wb_dat_i[WD_RSTEN_BIT];
                    if (wb_dat_i[WD_POR_BIT]) begin
                        next_por_flag = 1'b0;
                    end
                end
                ADR_IRQ_MASK: begin
                    next_irq_mask = wb_dat_i[EV_N-1:0];
                end
                default: begin
                end
            endcase
        end
        if (por_i) begin
            next_cause = '0; // [RULE11] [RULE13] [RULE15]
            next_por_flag = 1'b1; // [RULE9]
        end
        if (rd) begin
            unique case (wb_adr_i)
                ADR_CAUSE: next_dat[2:0] = cause; // [RULE17]
                ADR_DBGCTL: next_dat[DBG_RST_BIT] = dbg_rst;
                ADR_WDCTL: begin
                    next_dat[WD_RSTEN_BIT] = wd_rst_en;
                    next_dat[WD_POR_BIT] = por_flag; // [RULE9]
                end
                ADR_IRQ_STAT: next_dat[EV_N-1:0] = irq_stat;
                ADR_IRQ_MASK: next_dat[EV_N-1:0] = irq_mask;
                default: next_dat = 32'h0000_0000;
            endcase
        end
        // Built from next values, so the level tracks its own flops
        next_irq_stat = (irq_stat & ~w1c) | ev;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ************************************************************
    // Flip-flops
    // ************************************************************
    // The debug control bit clears only on rst_i or by its own self-clear, so the debugger
    // keeps its state across the system resets it requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_HOLD;
            cnt <= 16'h0000;
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_cnt <= 2'h0;
            cause <= '0;
            por_flag <= 1'b1;
            wd_rst_en <= WD_RSTEN_RST;
            dbg_rst <= 1'b0;
            irq_stat <= '0;
            irq_mask <= '0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            sys_rst_o <= 1'b1;
            vec_req_o <= 1'b0;
            vec_addr_o <= 16'h0000;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            cnt <= next_cnt;
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
            pin_cnt <= next_pin_cnt;
            cause <= next_cause;
            por_flag <= next_por_flag;
            wd_rst_en <= next_wd_rst_en;
            dbg_rst <= next_dbg_rst;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            sys_rst_o <= next_sys_rst;
            vec_req_o <= next_vec_req;
            vec_addr_o <= next_vec_addr;
            irq_o <= next_irq;
        end
    end
endmodule

// File: rtl/rsl_pkg.sv
// Constants and types shared by the reset source and status logic
package rsl_pkg;
    // ************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [7:0] ADR_CAUSE = 8'h00;
    localparam logic [7:0] ADR_DBGCTL = 8'h04;
    localparam logic [7:0] ADR_WDCTL = 8'h08;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int DBG_RST_BIT = 0;
    localparam int WD_RSTEN_BIT = 0;
    localparam int WD_POR_BIT = 7;
    localparam logic WD_RSTEN_RST = 1'b1;
    localparam int EV_POR = 0;
    localparam int EV_WDT = 1;
    localparam int EV_PIN = 2;
    localparam int EV_STOP = 3;
    localparam int EV_DBG = 4;
    localparam int EV_N = 5;
    localparam logic [15:0] RESET_VEC = 16'h0002;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_KHZ = 10000;
    localparam int POR_US = 1000;
    localparam int POR_XTAL_US = 5000;
    localparam int POR_CYC = POR_US * CLK_KHZ / 1000;
    localparam int POR_XTAL_CYC = POR_XTAL_US * CLK_KHZ / 1000;
    localparam logic [1:0] PIN_MIN_CYC = 2'h3;

    // Cause flags: ext in bit 0, watchdog in bit 1, stop in bit 2
    typedef struct packed {
        logic stop_rec;
        logic wdt;
        logic pin_reset_flag;
    } rsl_cause_t;

    typedef enum logic [1:0] {
        S_HOLD,
        S_DELAY,
        S_FETCH,
        S_RUN
    } rsl_state_t;
endpackage

// File: test/rsl_properties.sv
// Port-level checks on the reset sequencer
`timescale 1ns/1ps
module rsl_properties
    import rsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic por_i,
    input wire logic stop_mode_i,
    input wire logic pin_reset_n_i,
    input wire logic stop_pin_reset_n_i,
    input wire logic debug_pin_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sys_rst_o,
    input wire logic vec_req_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (
        wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat idle");
    a_dat_upper: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("dat hi");
    a_por_hold: assert property (
        por_i && ce_i |=> sys_rst_o) else $error("released under por");
    a_por_delay: assert property (
        $fell(por_i) |-> sys_rst_o [*8]) else $error("por delay short");
    a_pin_long: assert property (
        (!pin_reset_n_i && !stop_mode_i) [*6] |-> ##[0:2] sys_rst_o)
        else $error("pin reset missed");
    a_stop_src: assert property (
        stop_mode_i && (!debug_pin_i || !stop_pin_reset_n_i) && ce_i
        |=> sys_rst_o) else $error("stop source missed");
    a_fetch_vec: assert property (
        $fell(sys_rst_o) |-> vec_req_o && vec_addr_o == RESET_VEC)
        else $error("no reset fetch");
    a_no_fetch_held: assert property (
        sys_rst_o |-> !vec_req_o) else $error("fetch while held");
    cover property ($fell(sys_rst_o));
    cover property (wb_ack_o && wb_dat_o != 32'h0000_0000);
    cover property ($rose(irq_o));
endmodule
bind rsl_top rsl_properties i_rsl_properties (.*);

// File: test/rsl_core_model.sv
// Processor core model: records reset and trap vector fetches
`timescale 1ns/1ps
module rsl_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic held_i,
    input wire logic vec_req_i,
    input wire logic [15:0] vec_addr_i,
    output logic [7:0] fetch_cnt_o,
    output logic [15:0] last_vec_o
);
    // Core stays idle while held; it only runs after a fetch
    always @(posedge clk_i) begin
        if (rst_i) begin
            fetch_cnt_o <= 8'h00;
            last_vec_o <= 16'h0000;
        end else if (!held_i && vec_req_i) begin
            fetch_cnt_o <= fetch_cnt_o + 8'h01;
            last_vec_o <= vec_addr_i;
        end
    end
endmodule

// File: test/testbench.sv
// Self-checking bench for the reset source and status logic
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench
    import rsl_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, e;
    logic por_i = 1'b1, xtal_en_i = 1'b0, stop_mode_i = 1'b0;
    logic pin_reset_n_i = 1'b1, stop_pin_reset_n_i = 1'b1;
    logic debug_pin_i = 1'b1, wdt_timeout_i = 1'b0, stop_rec_i = 1'b0;
    logic stop_rec_pin_i = 1'b0, trap_req_i = 1'b0;
    logic [15:0] trap_vec_i = 16'h0000, vec_addr_o, last_vec;
    logic wb_ack_o, sys_rst_o, vec_req_o, irq_o;
    logic [7:0] fetch_cnt, msk;
    logic [31:0] expq[$];
    int bad_count = 0, cmp_count = 0, seed = 23, n;
    rsl_top #(.POR_CYCLES(8), .POR_XTAL_CYCLES(16)) i_rsl_top (.*);
    rsl_core_model i_rsl_core_model (.clk_i(clk_i), .rst_i(rst_i),
        .held_i(sys_rst_o), .vec_req_i(vec_req_o),
        .vec_addr_i(vec_addr_o), .fetch_cnt_o(fetch_cnt),
        .last_vec_o(last_vec));
    initial forever #50 clk_i = ~clk_i;
    task automatic cyc_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, ex);
        expq.push_back({24'h00_0000, ex});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic rel(output int k);
        k = 0;
        while (sys_rst_o !== 1'b0 && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        `CHK("release", 1'b1, k < 200)
        cyc_n(1);
    endtask
    task automatic wdt();
        wdt_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdt_timeout_i <= 1'b0;
        cyc_n(2);
    endtask
    task automatic rec(input logic p);
        stop_rec_pin_i <= p;
        stop_rec_i <= 1'b1;
        @(posedge clk_i);
        stop_rec_i <= 1'b0;
        cyc_n(1);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Read results are compared in order of issue
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
            e = expq.pop_front();
            `CHK("rdata", e, wb_dat_o)
        end
    end
    initial begin
        cyc_n(20000);
        bad_count++;
        print_verdict();
    end
    initial begin
        cyc_n(12);
        rst_i <= 1'b0;
        cyc_n(3);
        por_i <= 1'b0;
        rel(n);
        `CHK("por_len", 1'b1, n >= 8 && n < 16)
        `CHK("fetches", 8'h01, fetch_cnt)
        `CHK("vector", RESET_VEC, last_vec)
        rd(ADR_WDCTL, 8'h81);
        rd(ADR_CAUSE, 8'h00);
        rd(ADR_IRQ_STAT, 8'h01);
        bus(1'b1, ADR_IRQ_MASK, 8'h01);
        `CHK("irq_on", 1'b1, irq_o)
        bus(1'b1, ADR_IRQ_STAT, 8'h01);
        `CHK("irq_off", 1'b0, irq_o)
        bus(1'b1, ADR_WDCTL, 8'h81);
        rd(ADR_WDCTL, 8'h01);
        msk = 8'($random(seed));
        bus(1'b1, ADR_IRQ_MASK, msk);
        rd(ADR_IRQ_MASK, msk & 8'h1f);
        wb_sel_i <= 4'he;
        bus(1'b1, ADR_IRQ_MASK, ~msk);
        wb_sel_i <= 4'hf;
        rd(ADR_IRQ_MASK, msk & 8'h1f);
        rd(8'h40, 8'h00);
        // Widths 1..6 straddle the three-clock filter edge
        for (int w = 1; w <= 6; w++) begin
            pin_reset_n_i <= 1'b0;
            cyc_n(w);
            pin_reset_n_i <= 1'b1;
            cyc_n(5);
            `CHK("pin_rst", w >= 3, sys_rst_o)
            rel(n);
        end
        rd(ADR_CAUSE, 8'h01);
        rd(ADR_CAUSE, 8'h00);
        wdt();
        `CHK("wdt_rst", 1'b1, sys_rst_o)
        rel(n);
        rd(ADR_CAUSE, 8'h02);
        bus(1'b1, ADR_IRQ_STAT, 8'h02);
        rd(ADR_IRQ_STAT, 8'h04);
        bus(1'b1, ADR_WDCTL, 8'h00);
        wdt();
        `CHK("wdt_off", 1'b0, sys_rst_o)
        stop_mode_i <= 1'b1;
        rec(1'b0);
        rd(ADR_CAUSE, 8'h06);
        rec(1'b0);
        stop_mode_i <= 1'b0;
        wdt();
        rd(ADR_CAUSE, 8'h02);
        stop_mode_i <= 1'b1;
        stop_pin_reset_n_i <= 1'b0;
        @(posedge clk_i);
        stop_pin_reset_n_i <= 1'b1;
        cyc_n(2);
        `CHK("stop_pin", 1'b1, sys_rst_o)
        rel(n);
        wdt();
        rec(1'b1);
        rd(ADR_CAUSE, 8'h04);
        debug_pin_i <= 1'b0;
        @(posedge clk_i);
        debug_pin_i <= 1'b1;
        cyc_n(2);
        `CHK("dbg_pin", 1'b1, sys_rst_o)
        rel(n);
        stop_mode_i <= 1'b0;
        bus(1'b1, ADR_DBGCTL, 8'h01);
        cyc_n(2);
        `CHK("dbg_rst", 1'b1, sys_rst_o)
        ce_i <= 1'b0;
        cyc_n(20);
        `CHK("ce_hold", 1'b1, sys_rst_o)
        ce_i <= 1'b1;
        rel(n);
        rd(ADR_DBGCTL, 8'h00);
        wdt();
        xtal_en_i <= 1'b1;
        por_i <= 1'b1;
        cyc_n(3);
        por_i <= 1'b0;
        rel(n);
        `CHK("xtal_len", 1'b1, n >= 16 && n < 40)
        rd(ADR_CAUSE, 8'h00);
        repeat (4) begin
            trap_vec_i <= 16'($random(seed));
            trap_req_i <= 1'b1;
            @(posedge clk_i);
            trap_req_i <= 1'b0;
            cyc_n(3);
            `CHK("trap_vec", trap_vec_i, last_vec)
        end
        cyc_n(2);
        print_verdict();
    end
endmodule
